// *** pkg/sbsc_pkg.sv ***
// package of constants and types for the burst sram cycle decoder
// assumes a single rising-edge clock domain; no bus, all control on plain pins
// Functional notes
// - deselect and float when selects or strobes say
// - begin read at external address on strobes
// - processor-strobe start is always a read
// - controller strobe with write qualifier begins write
// - no strobe, step low, no write: next read
// - no strobe, step low, write: next write
// - no strobe, step high, no write: reread current
// - no strobe, step high, write: rewrite current
// - write qualifier from global or lane writes
// - all write inputs inactive means read
// - write only selected lanes; global writes both
// - output enable masked during write cycles
// - read drives data while enable low
// - sleep input floats pins, two-cycle entry/exit
// - wrapping two-bit counter, linear or interleaved
package sbsc_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int unsigned LANES      = 2;
  localparam int unsigned BURST_W    = 2;
  localparam int unsigned SLEEP_CYC  = 2;

  localparam logic [BURST_W-1:0] STEP_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] STEP_INC   = 2'h1;
  localparam logic [LANES-1:0]   LANES_NONE = 2'h0;
  localparam logic [LANES-1:0]   LANES_ALL  = 2'h3;

  // ****************************************
  // cycle kinds
  // ****************************************
  typedef enum logic [3:0] {
    CYC_IDLE,
    CYC_DESEL,
    CYC_SLEEP,
    CYC_BEGIN_RD,
    CYC_BEGIN_WR,
    CYC_NEXT_RD,
    CYC_NEXT_WR,
    CYC_HOLD_RD,
    CYC_HOLD_WR
  } sbsc_cyc_t;

  // sampled synchronous control pins
  typedef struct packed {
    logic chip_sel_primary_n;
    logic chip_sel_depth_hi;
    logic chip_sel_depth_lo_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
    logic global_wr_n;
    logic byte_wr_enable_n;
    logic lane1_wr_sel_n;
    logic lane0_wr_sel_n;
  } sbsc_ctl_t;

  // burst position: start address low bits, step count, order
  typedef struct packed {
    logic [BURST_W-1:0] base;
    logic [BURST_W-1:0] step;
    logic               interleave;
  } sbsc_burst_t;

endpackage : sbsc_pkg

// *** verilog/sbsc_mem.sv ***
// storage array with per-lane write and registered read data
// assumes address, lanes and data are stable at the clock edge they act on
`timescale 1ns/1ps
`default_nettype none

module sbsc_mem #(
  parameter int unsigned ADDR_W = 10,
  parameter int unsigned LANE_W = 9,
  parameter int unsigned LANES  = sbsc_pkg::LANES
) (
  input  wire logic                      core_clk,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic                      rd_en,
  input  wire logic [LANES-1:0]          wr_lanes,
  input  wire logic [LANES*LANE_W-1:0]   wdata,
  output var  logic [LANES*LANE_W-1:0]   rdata_r
);

  localparam int unsigned DEPTH = 1 << ADDR_W;

  // ****************************************
  // one array per lane
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] arr [DEPTH];

      always_ff @(posedge core_clk) begin
        if (wr_lanes[g]) begin
          arr[addr] <= wdata[g*LANE_W +: LANE_W];
        end
      end

      // reading a lane written in the same edge returns the old word
      always_ff @(posedge core_clk) begin
        if (rd_en) begin
          rdata_r[g*LANE_W +: LANE_W] <= arr[addr];
        end
      end
    end
  endgenerate

endmodule : sbsc_mem

`default_nettype wire

// *** verilog/sbsc_top.sv ***
// cycle decoder, byte-write qualifier, burst counter, sleep and read buffer
// assumes all pins synchronous to core_clk; data pin is split in, out, enable
`timescale 1ns/1ps
`default_nettype none

module sbsc_top #(
  parameter int unsigned ADDR_W = 10,
  parameter int unsigned LANE_W = 9
) (
  input  wire logic                                core_clk,
  input  wire logic                                resetn,
  input  wire logic                                chip_sel_primary_n,
  input  wire logic                                chip_sel_depth_hi,
  input  wire logic                                chip_sel_depth_lo_n,
  input  wire logic                                sleep_req,
  input  wire logic                                proc_addr_strobe_n,
  input  wire logic                                ctrl_addr_strobe_n,
  input  wire logic                                burst_step_n,
  input  wire logic                                global_wr_n,
  input  wire logic                                byte_wr_enable_n,
  input  wire logic                                lane0_wr_sel_n,
  input  wire logic                                lane1_wr_sel_n,
  input  wire logic                                out_en_n,
  input  wire logic                                burst_order,
  input  wire logic [ADDR_W-1:0]                   addr,
  input  wire logic [sbsc_pkg::LANES*LANE_W-1:0]   dq_in,
  output var  logic [sbsc_pkg::LANES*LANE_W-1:0]   dq_out,
  output var  logic                                dq_oe_r,
  output var  logic [sbsc_pkg::LANES*LANE_W-1:0]   rd_data_r,
  output var  logic                                rd_valid_r,
  input  wire logic                                rd_ready,
  output var  logic                                rd_stall_r,
  output var  logic                                sleeping_r,
  output var  sbsc_pkg::sbsc_cyc_t                 cycle_r
);

  localparam int unsigned BW = sbsc_pkg::BURST_W;
  localparam int unsigned DW = sbsc_pkg::LANES * LANE_W;

  // ****************************************
  // pin grouping
  // ****************************************
  sbsc_pkg::sbsc_ctl_t ctl;

  assign ctl = '{
    chip_sel_primary_n:  chip_sel_primary_n,
    chip_sel_depth_hi:   chip_sel_depth_hi,
    chip_sel_depth_lo_n: chip_sel_depth_lo_n,
    proc_addr_strobe_n:  proc_addr_strobe_n,
    ctrl_addr_strobe_n:  ctrl_addr_strobe_n,
    burst_step_n:        burst_step_n,
    global_wr_n:         global_wr_n,
    byte_wr_enable_n:    byte_wr_enable_n,
    lane1_wr_sel_n:      lane1_wr_sel_n,
    lane0_wr_sel_n:      lane0_wr_sel_n
  };

  // ****************************************
  // sleep entry and exit
  // ****************************************
  logic [sbsc_pkg::SLEEP_CYC-1:0] sleep_hist_r;
  logic [sbsc_pkg::SLEEP_CYC-1:0] sleep_hist_nxt;
  logic                           sleeping_nxt;
  logic                           quiet;

  assign sleep_hist_nxt = {sleep_hist_r[sbsc_pkg::SLEEP_CYC-2:0], sleep_req};
  // the flag follows only a full run of equal samples, so entry and exit take two edges
  assign sleeping_nxt   = (&sleep_hist_nxt) ? 1'b1 :
                          (~|sleep_hist_nxt) ? 1'b0 : sleeping_r;
  // any raised request already masks the other pins
  assign quiet          = sleep_req | sleeping_r;

  // ****************************************
  // write qualifier and lanes
  // ****************************************
  logic [sbsc_pkg::LANES-1:0] lane_sel;
  logic                       wr_q;

  assign lane_sel = !ctl.global_wr_n     ? sbsc_pkg::LANES_ALL :
                    !ctl.byte_wr_enable_n ? ~{ctl.lane1_wr_sel_n, ctl.lane0_wr_sel_n} :
                    sbsc_pkg::LANES_NONE;
  assign wr_q     = |lane_sel;

  // ****************************************
  // cycle decode
  // ****************************************
  logic all_sel;
  logic proc_start;
  logic ctrl_start;
  logic desel;
  logic begin_c;
  logic no_start;
  logic burst_open_r;
  sbsc_pkg::sbsc_cyc_t cyc;

  assign all_sel    = !ctl.chip_sel_primary_n & ctl.chip_sel_depth_hi
                      & !ctl.chip_sel_depth_lo_n;
  // processor strobe counts only with the primary select low
  assign proc_start = !ctl.proc_addr_strobe_n & !ctl.chip_sel_primary_n;
  assign ctrl_start = !ctl.ctrl_addr_strobe_n;
  assign desel      = (ctl.chip_sel_primary_n & ctrl_start)
                      | (!all_sel & (proc_start | ctrl_start));
  assign begin_c    = all_sel & (proc_start | ctrl_start);
  assign no_start   = !proc_start & !ctrl_start;

  always_comb begin
    cyc = sbsc_pkg::CYC_IDLE;
    if (quiet) begin
      cyc = sbsc_pkg::CYC_SLEEP;
    end else if (desel) begin
      cyc = sbsc_pkg::CYC_DESEL;
    end else if (begin_c) begin
      if (proc_start || !wr_q) begin
        cyc = sbsc_pkg::CYC_BEGIN_RD;
      end else begin
        cyc = sbsc_pkg::CYC_BEGIN_WR;
      end
    end else if (no_start && burst_open_r) begin
      if (!ctl.burst_step_n) begin
        cyc = wr_q ? sbsc_pkg::CYC_NEXT_WR : sbsc_pkg::CYC_NEXT_RD;
      end else begin
        cyc = wr_q ? sbsc_pkg::CYC_HOLD_WR : sbsc_pkg::CYC_HOLD_RD;
      end
    end
  end

  logic is_begin;
  logic is_next;
  logic is_rd;
  logic is_wr;

  assign is_begin = (cyc == sbsc_pkg::CYC_BEGIN_RD) | (cyc == sbsc_pkg::CYC_BEGIN_WR);
  assign is_next  = (cyc == sbsc_pkg::CYC_NEXT_RD) | (cyc == sbsc_pkg::CYC_NEXT_WR);
  assign is_rd    = (cyc == sbsc_pkg::CYC_BEGIN_RD) | (cyc == sbsc_pkg::CYC_NEXT_RD)
                    | (cyc == sbsc_pkg::CYC_HOLD_RD);
  assign is_wr    = (cyc == sbsc_pkg::CYC_BEGIN_WR) | (cyc == sbsc_pkg::CYC_NEXT_WR)
                    | (cyc == sbsc_pkg::CYC_HOLD_WR);

  // ****************************************
  // burst address
  // ****************************************
  sbsc_pkg::sbsc_burst_t burst_r;
  sbsc_pkg::sbsc_burst_t burst_nxt;
  logic [ADDR_W-1:0]     hi_r;
  logic                  burst_open_nxt;
  logic [BW-1:0]         step_use;
  logic [BW-1:0]         lo_use;
  logic [ADDR_W-1:0]     mem_addr;

  assign burst_nxt = is_begin ? '{base: addr[BW-1:0], step: sbsc_pkg::STEP_FIRST,
                                  interleave: burst_order} :
                     is_next  ? '{base: burst_r.base,
                                  step: BW'(burst_r.step + sbsc_pkg::STEP_INC),
                                  interleave: burst_r.interleave} :
                     burst_r;
  // the address for this edge uses the step it is about to hold
  assign step_use  = burst_nxt.step;
  assign lo_use    = burst_nxt.interleave ? (burst_nxt.base ^ step_use) :
                     BW'(burst_nxt.base + step_use);
  assign mem_addr  = is_begin ? addr : {hi_r[ADDR_W-1:BW], lo_use};
  // a burst stays open until a deselect or sleep closes it
  assign burst_open_nxt = is_begin ? 1'b1 :
                          ((cyc == sbsc_pkg::CYC_DESEL) || (cyc == sbsc_pkg::CYC_SLEEP)) ?
                          1'b0 : burst_open_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      burst_r <= '0;
    end else begin
      burst_r <= burst_nxt;
    end
  end

  // upper address bits ride along from the begin cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hi_r <= '0;
    end else begin
      hi_r <= mem_addr;
    end
  end

  // closed after reset so a stray step cannot run off an old address
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      burst_open_r <= 1'b0;
    end else begin
      burst_open_r <= burst_open_nxt;
    end
  end

  // ****************************************
  // array
  // ****************************************
  logic [sbsc_pkg::LANES-1:0] wr_lanes;

  // lanes and data go to the array at the decode edge
  assign wr_lanes = is_wr ? lane_sel : sbsc_pkg::LANES_NONE;

  sbsc_mem #(
    .ADDR_W   (ADDR_W),
    .LANE_W   (LANE_W),
    .LANES    (sbsc_pkg::LANES)
  ) u_mem (
    .core_clk (core_clk),
    .addr     (mem_addr),
    .rd_en    (is_rd),
    .wr_lanes (wr_lanes),
    .wdata    (dq_in),
    .rdata_r  (dq_out)
  );

  // ****************************************
  // data pin enable and status
  // ****************************************
  logic dq_oe_nxt;
  logic rd_pend_r;

  // enable is qualified with the cycle each edge; a write clears it at once
  assign dq_oe_nxt = is_rd & !out_en_n;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dq_oe_r <= 1'b0;
    end else begin
      dq_oe_r <= dq_oe_nxt;
    end
  end

  // marks the edge after a read, when the word stands on dq_out
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= is_rd;
    end
  end

  // history starts awake, so no sleep entry right after reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_hist_r <= '0;
    end else begin
      sleep_hist_r <= sleep_hist_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sleeping_r <= 1'b0;
    end else begin
      sleeping_r <= sleeping_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cycle_r <= sbsc_pkg::CYC_IDLE;
    end else begin
      cycle_r <= cyc;
    end
  end

  // ****************************************
  // two-entry read buffer
  // ****************************************
  // a word arrives one edge after its read; the skid slot keeps it when the
  // receiver stalls, and rd_stall_r tells the host to hold off new reads
  logic          push;
  logic          pop;
  logic          take;
  logic [DW-1:0] skid_data_r;
  logic          skid_valid_r;

  assign push = rd_pend_r & !skid_valid_r;
  assign pop  = rd_valid_r & rd_ready;
  assign take = !rd_valid_r | pop;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_valid_r   <= 1'b0;
      skid_valid_r <= 1'b0;
    end else if (take) begin
      rd_valid_r   <= skid_valid_r | push;
      skid_valid_r <= 1'b0;
    end else if (push) begin
      skid_valid_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (take) begin
      rd_data_r <= skid_valid_r ? skid_data_r : dq_out;
    end
    if (!take && push) begin
      skid_data_r <= dq_out;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_stall_r <= 1'b0;
    end else begin
      rd_stall_r <= (skid_valid_r & !take) | (!take & push);
    end
  end

endmodule : sbsc_top

`default_nettype wire

// *** sim/sbsc_host_model.sv ***
// partner: processor side of the common data bus and of the output enable
// assumes the bench raises host_drv for exactly the cycles it decodes as writes
`timescale 1ns/1ps
`default_nettype none

module sbsc_host_model (
  input  wire logic        core_clk,
  input  wire logic        host_drv,
  input  wire logic        out_en_req_n,
  input  wire logic [17:0] wdata,
  input  wire logic [17:0] dq_out,
  input  wire logic        dq_oe_r,
  output var  logic [17:0] dq_in,
  output var  logic        out_en_n
);
  logic [17:0] last_r = 18'h0;

  // enable forced inactive around writes so the device lets go of the bus
  assign out_en_n = out_en_req_n | host_drv;
  // a released bus shows the inverse of its last level, never a held copy
  always_comb begin
    if (host_drv) dq_in = wdata;
    else if (dq_oe_r) dq_in = dq_out;
    else dq_in = ~last_r;
  end
  always_ff @(posedge core_clk) last_r <= dq_in;
endmodule : sbsc_host_model
`default_nettype wire

// *** sim/sbsc_top_sva.sv ***
// checker: timing relations between the decoder's pins and its outputs
// assumes it is bound into sbsc_top and sees that module's ports only
`timescale 1ns/1ps
`default_nettype none

module sbsc_top_chk #(
  parameter int unsigned ADDR_W = 10,
  parameter int unsigned LANE_W = 9
) (
  input wire logic                              core_clk,
  input wire logic                              resetn,
  input wire logic                              chip_sel_primary_n,
  input wire logic                              chip_sel_depth_hi,
  input wire logic                              chip_sel_depth_lo_n,
  input wire logic                              sleep_req,
  input wire logic                              proc_addr_strobe_n,
  input wire logic                              ctrl_addr_strobe_n,
  input wire logic                              global_wr_n,
  input wire logic                              out_en_n,
  input wire logic                              dq_oe_r,
  input wire logic [sbsc_pkg::LANES*LANE_W-1:0] rd_data_r,
  input wire logic                              rd_valid_r,
  input wire logic                              rd_ready,
  input wire logic                              rd_stall_r,
  input wire logic                              sleeping_r,
  input wire sbsc_pkg::sbsc_cyc_t               cycle_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  wire sel_ok = !chip_sel_primary_n && chip_sel_depth_hi && !chip_sel_depth_lo_n;
  wire awake  = !sleep_req && !sleeping_r;
  wire is_rd  = cycle_r inside {sbsc_pkg::CYC_BEGIN_RD, sbsc_pkg::CYC_NEXT_RD,
                                sbsc_pkg::CYC_HOLD_RD};
  wire is_wr  = cycle_r inside {sbsc_pkg::CYC_BEGIN_WR, sbsc_pkg::CYC_NEXT_WR,
                                sbsc_pkg::CYC_HOLD_WR};

  a_write_masks_oe: assert property (is_wr |-> !dq_oe_r)
    else $error("data pins enabled in a write cycle");
  a_oe_needs_read: assert property (dq_oe_r |-> is_rd && !$past(out_en_n))
    else $error("data pins enabled outside an enabled read");
  a_read_drives: assert property (is_rd && !$past(out_en_n) |-> dq_oe_r)
    else $error("enabled read left data pins floating");
  a_sleep_floats: assert property (sleeping_r |->
    cycle_r == sbsc_pkg::CYC_SLEEP && !dq_oe_r)
    else $error("sleep state not idle and floating");
  a_sleep_entry: assert property (sleep_req ##1 sleep_req |=> sleeping_r)
    else $error("sleep not entered after two samples");
  a_sleep_exit: assert property (!sleep_req [*2] |=> !sleeping_r)
    else $error("sleep not left after two samples");
  a_sleep_ignores: assert property (sleep_req |=> cycle_r == sbsc_pkg::CYC_SLEEP)
    else $error("inputs not ignored while sleep requested");
  a_proc_reads: assert property (awake && sel_ok && !proc_addr_strobe_n
    |=> cycle_r == sbsc_pkg::CYC_BEGIN_RD)
    else $error("processor strobe did not begin a read");
  a_ctrl_writes: assert property (awake && sel_ok && proc_addr_strobe_n
    && !ctrl_addr_strobe_n && !global_wr_n |=> cycle_r == sbsc_pkg::CYC_BEGIN_WR && !dq_oe_r)
    else $error("controller strobe with write did not begin a write");
  a_desel_floats: assert property (awake && chip_sel_primary_n && !ctrl_addr_strobe_n
    |=> cycle_r == sbsc_pkg::CYC_DESEL && !dq_oe_r)
    else $error("deselect not decoded or pins not floated");
  a_desel_closes: assert property (cycle_r == sbsc_pkg::CYC_DESEL && awake
    && ctrl_addr_strobe_n && (proc_addr_strobe_n || chip_sel_primary_n)
    |=> cycle_r == sbsc_pkg::CYC_IDLE)
    else $error("burst continued after a deselect");
  a_skid_behind: assert property (rd_stall_r |-> rd_valid_r)
    else $error("skid slot full with empty output slot");
  a_word_holds: assert property (rd_valid_r && !rd_ready |=> rd_valid_r && $stable(rd_data_r))
    else $error("stalled read word changed or vanished");
endmodule : sbsc_top_chk

bind sbsc_top sbsc_top_chk #(.ADDR_W(ADDR_W), .LANE_W(LANE_W)) u_chk (.core_clk, .resetn,
  .chip_sel_primary_n, .chip_sel_depth_hi, .chip_sel_depth_lo_n, .sleep_req,
  .proc_addr_strobe_n, .ctrl_addr_strobe_n, .global_wr_n, .out_en_n, .dq_oe_r, .rd_data_r,
  .rd_valid_r, .rd_ready, .rd_stall_r, .sleeping_r, .cycle_r);
`default_nettype wire

// *** sim/sbsc_top_tb.sv ***
// bench: directed then random pin traffic checked against a cycle-level model
// assumes default sizes of sbsc_top and the host model on the data bus
`timescale 1ns/1ps
`default_nettype none

module sbsc_top_tb;
  logic                core_clk = 1'b0, resetn = 1'b0, run = 1'b0;
  sbsc_pkg::sbsc_ctl_t ctl = 10'h26f, nc;
  logic                sleep_req = 1'b0, out_en_req_n = 1'b1, burst_order = 1'b0;
  logic                host_drv = 1'b0, rd_ready = 1'b1, out_en_n;
  logic                dq_oe_r, rd_valid_r, rd_stall_r, sleeping_r;
  logic [9:0]          addr = 10'h0;
  logic [17:0]         wdata = 18'h0, dq_in, dq_out, rd_data_r, edat, w;
  logic [17:0]         mem [1024];
  logic [17:0]         q [$];
  sbsc_pkg::sbsc_cyc_t cycle_r, c, ecyc = sbsc_pkg::CYC_IDLE;
  logic [31:0]         seed = 32'h749b, r;
  logic [7:0]          hi = 8'h0;
  logic [1:0]          base = 2'h0, stp = 2'h0, lo, ln;
  logic                msleep = 1'b0, sprev = 1'b0, open = 1'b0, il = 1'b0, eoe = 1'b0;
  // read buffer model: output slot, skid slot, read word in flight
  logic                mv = 1'b0, ms = 1'b0, mp = 1'b0;
  int                  failures = 0, tests_run = 0, n = 0, scnt = 0;
  // corner cases first: proc strobe with global write, lane writes, deselect, step after deselect
  logic [31:0]         dir [8] = '{32'h3430184, 32'h42d6c4, 32'h42e7c4, 32'h3423644,
                                   32'h420ec4, 32'h420e47, 32'h420ec4, 32'h542c644};

  always #12.5 core_clk = ~core_clk;

  sbsc_top DUT (.core_clk, .resetn, .sleep_req, .out_en_n, .burst_order, .addr, .dq_in,
    .chip_sel_primary_n(ctl.chip_sel_primary_n), .chip_sel_depth_hi(ctl.chip_sel_depth_hi),
    .chip_sel_depth_lo_n(ctl.chip_sel_depth_lo_n), .burst_step_n(ctl.burst_step_n),
    .proc_addr_strobe_n(ctl.proc_addr_strobe_n), .ctrl_addr_strobe_n(ctl.ctrl_addr_strobe_n),
    .global_wr_n(ctl.global_wr_n), .byte_wr_enable_n(ctl.byte_wr_enable_n),
    .lane0_wr_sel_n(ctl.lane0_wr_sel_n), .lane1_wr_sel_n(ctl.lane1_wr_sel_n), .dq_out,
    .dq_oe_r, .rd_data_r, .rd_valid_r, .rd_ready, .rd_stall_r, .sleeping_r, .cycle_r);
  sbsc_host_model u_host (.core_clk, .host_drv, .out_en_req_n, .wdata, .dq_out, .dq_oe_r,
    .dq_in, .out_en_n);

  // ****************************************
  // expectation helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic sbsc_pkg::sbsc_cyc_t dec(sbsc_pkg::sbsc_ctl_t p, logic s, logic op);
    logic wq, sel, pr, cr;
    wq = !p.global_wr_n || (!p.byte_wr_enable_n && !(p.lane0_wr_sel_n && p.lane1_wr_sel_n));
    sel = p.chip_sel_depth_hi && !p.chip_sel_depth_lo_n;
    pr = p.proc_addr_strobe_n;
    cr = p.ctrl_addr_strobe_n;
    if (s) return sbsc_pkg::CYC_SLEEP;
    if (p.chip_sel_primary_n ? !cr : (!sel && !(pr && cr))) return sbsc_pkg::CYC_DESEL;
    if (!p.chip_sel_primary_n && !(pr && cr))
      return (!pr || !wq) ? sbsc_pkg::CYC_BEGIN_RD : sbsc_pkg::CYC_BEGIN_WR;
    if (!op) return sbsc_pkg::CYC_IDLE;
    if (!p.burst_step_n) return wq ? sbsc_pkg::CYC_NEXT_WR : sbsc_pkg::CYC_NEXT_RD;
    return wq ? sbsc_pkg::CYC_HOLD_WR : sbsc_pkg::CYC_HOLD_RD;
  endfunction : dec

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  // one process checks the last edge, steps the model and drives the next pins
  always @(posedge core_clk) if (run) begin
    chk("cycle_r", cycle_r, ecyc);
    chk("sleeping_r", sleeping_r, msleep);
    chk("dq_oe_r", dq_oe_r, eoe);
    chk("rd_valid_r", rd_valid_r, mv);
    chk("rd_stall_r", rd_stall_r, ms);
    if (eoe && !$isunknown(edat)) chk("dq_out", dq_out, edat);
    if (rd_valid_r && rd_ready) begin
      w = q.size() ? q.pop_front() : 18'hx;
      if (!$isunknown(w)) chk("rd_data_r", rd_data_r, w);
    end
    if (!mv || rd_ready) begin
      mv = ms || mp;
      ms = 1'b0;
    end else if (mp) begin
      ms = 1'b1;
    end
    c = dec(ctl, sleep_req || msleep, open);
    ecyc = c;
    if (c inside {sbsc_pkg::CYC_BEGIN_RD, sbsc_pkg::CYC_BEGIN_WR}) begin
      {hi, base} = addr;
      stp = 2'h0;
      il = burst_order;
      open = 1'b1;
    end
    if (c inside {sbsc_pkg::CYC_DESEL, sbsc_pkg::CYC_SLEEP}) open = 1'b0;
    if (c inside {sbsc_pkg::CYC_NEXT_RD, sbsc_pkg::CYC_NEXT_WR}) stp = stp + 2'h1;
    lo = il ? base ^ stp : base + stp;
    edat = mem[{hi, lo}];
    eoe = (c inside {sbsc_pkg::CYC_BEGIN_RD, sbsc_pkg::CYC_NEXT_RD, sbsc_pkg::CYC_HOLD_RD})
          && !out_en_n;
    if (c inside {sbsc_pkg::CYC_BEGIN_RD, sbsc_pkg::CYC_NEXT_RD, sbsc_pkg::CYC_HOLD_RD})
      q.push_back(edat);
    mp = c inside {sbsc_pkg::CYC_BEGIN_RD, sbsc_pkg::CYC_NEXT_RD, sbsc_pkg::CYC_HOLD_RD};
    if (c inside {sbsc_pkg::CYC_BEGIN_WR, sbsc_pkg::CYC_NEXT_WR, sbsc_pkg::CYC_HOLD_WR}) begin
      ln = !ctl.global_wr_n ? 2'h3 : ~{ctl.lane1_wr_sel_n, ctl.lane0_wr_sel_n};
      if (ln[0]) mem[{hi, lo}][8:0] = dq_in[8:0];
      if (ln[1]) mem[{hi, lo}][17:9] = dq_in[17:9];
    end
    if (sleep_req == sprev) msleep = sleep_req;
    sprev = sleep_req;
    r = (n < 8) ? dir[n] : rnd();
    n++;
    if (scnt > 0) scnt--;
    else if (r[21:17] == 5'h0) scnt = 4;
    nc = '{r[0] & r[1], r[2] | r[3], r[4] & r[5], r[6], r[7], r[8], r[9] | r[10], r[11],
           r[13], r[12]};
    c = dec(nc, scnt > 0 || msleep, open);
    // no read while two words are unclaimed, so the buffer never has to drop one
    if (c inside {sbsc_pkg::CYC_BEGIN_RD, sbsc_pkg::CYC_NEXT_RD, sbsc_pkg::CYC_HOLD_RD}
        && q.size() >= 2) begin
      nc.chip_sel_primary_n = 1'b1;
      nc.ctrl_addr_strobe_n = 1'b0;
    end
    ctl <= nc;
    sleep_req <= scnt > 0;
    host_drv <= dec(nc, scnt > 0 || msleep, open) inside {sbsc_pkg::CYC_BEGIN_WR,
                sbsc_pkg::CYC_NEXT_WR, sbsc_pkg::CYC_HOLD_WR};
    wdata <= 18'(rnd());
    out_en_req_n <= r[14] & r[15];
    burst_order <= r[16];
    rd_ready <= r[22] | r[23];
    addr <= {6'h0, r[27:24]};
  end

  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    run <= 1'b1;
    repeat (4000) @(posedge core_clk);
    print_verdict();
  end
endmodule : sbsc_top_tb
`default_nettype wire
